// ### hw/swmc_defs.svh
// Offsets, field positions and reset values of the serial wire block
`ifndef SWMC_DEFS_SVH
`define SWMC_DEFS_SVH

// ==========================================================
// Register byte offsets
`define SWMC_CTRL_OFS 12'h000
`define SWMC_STAT_OFS 12'h004
`define SWMC_DATA_OFS 12'h008
`define SWMC_PORT_OFS 12'h00C
`define SWMC_IRQ_EN_OFS 12'h010
`define SWMC_IRQ_CLR_OFS 12'h014

// ==========================================================
// Control register fields
`define SWMC_CTRL_TC 0
`define SWMC_CTRL_CLK 1
`define SWMC_CTRL_CS_LO 2
`define SWMC_CTRL_WM_LO 4
`define SWMC_CTRL_OIE 6
`define SWMC_CTRL_SIE 7

// ==========================================================
// Port register fields
`define SWMC_PORT_DO 0
`define SWMC_PORT_SDA 1
`define SWMC_PORT_SCL 2
`define SWMC_DDR_DO 4
`define SWMC_DDR_SDA 5
`define SWMC_DDR_SCL 6

// ==========================================================
// Status bits
`define SWMC_ST_START 0
`define SWMC_ST_OVF 1

// ==========================================================
// Reset values
`define SWMC_CTRL_RST 8'h00
`define SWMC_PORT_RST 8'h00
`define SWMC_DATA_RST 8'h00
`define SWMC_CNT_RST 4'h0

`endif

// ### hw/swmc_pkg.sv
// Types shared by the serial wire block
package swmc_pkg;
    typedef enum logic [1:0] {
        SWMC_WM_OFF = 2'h0,
        SWMC_WM_THREE = 2'h1,
        SWMC_WM_TWO = 2'h2,
        SWMC_WM_TWO_HOLD = 2'h3
    } swmc_wire_mode_e;

    typedef enum logic [1:0] {
        SWMC_CS_SOFT = 2'h0,
        SWMC_CS_TIMER = 2'h1,
        SWMC_CS_EXT_POS = 2'h2,
        SWMC_CS_EXT_NEG = 2'h3
    } swmc_clock_src_e;

    typedef enum logic [2:0] {
        SWMC_BUS_IDLE = 3'h1,
        SWMC_BUS_WRITE = 3'h2,
        SWMC_BUS_READ = 3'h4
    } swmc_bus_state_e;
endpackage

// ### hw/swmc_top.sv
// Wire-mode and clock-source selection for a universal serial interface
//
// Overview of operation
// - mode zero disables outputs, hold, start detector
// - three-wire: shift output replaces data-out port bit
// - three-wire: data-in and clock pins stay normal
// - two-wire: open-collector drivers gated by direction
// - SDA low when shift MSB or port zero
// - SCL low on port zero or start hold
// - start hold on SCL until flag cleared
// - two-wire disables SDA and SCL pull-ups, inputs unchanged
// - mode three also holds SCL after overflow
// - external clock latches output on opposite edge
// - source zero clocks only on strobe write
// - timer, external edges, counter both edges
// - strobe shifts, counts, reads as zero
// - external source: strobe bit selects counter clock
// - toggle write inverts clock port bit
// - external with strobe bit: toggle counts
// - serial output from shift register MSB
`timescale 1ns/1ps
`include "swmc_defs.svh"

module swmc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Timer overflow pulse, same clock
    input wire logic timer_ovf,
    // Data out pin
    input wire logic data_out_pin_in,
    output logic data_out_pin_out,
    output logic data_out_pin_oe,
    output logic data_out_pin_pullup,
    // Data in or SDA pin
    input wire logic serial_data_in_pin_in,
    output logic serial_data_in_pin_out,
    output logic serial_data_in_pin_oe,
    output logic serial_data_in_pin_pullup,
    // Clock or SCL pin
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    output logic serial_clock_pin_pullup,
    // Start condition event from the detector outside
    input wire logic start_detect,
    // Interrupt
    output logic irq
);
    import swmc_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync1_next;
    logic [2:0] sync2_reg;
    logic [2:0] sync2_next;
    logic scl_prev_reg;
    logic scl_prev_next;
    logic start_prev_reg;
    logic start_prev_next;

    always_comb
    begin
        sync1_next = {start_detect, serial_clock_pin_in,
                      serial_data_in_pin_in};
        sync2_next = sync1_reg;
        scl_prev_next = sync2_reg[1];
        start_prev_next = sync2_reg[2];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // Idle lines sit high, so no false edge follows reset
            sync1_reg <= 3'h3;
            sync2_reg <= 3'h3;
            scl_prev_reg <= 1'b1;
            start_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            scl_prev_reg <= scl_prev_next;
            start_prev_reg <= start_prev_next;
        end
    end

    logic din_s;
    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    assign din_s = sync2_reg[0];
    assign scl_rise = sync2_reg[1] & ~scl_prev_reg;
    assign scl_fall = ~sync2_reg[1] & scl_prev_reg;
    assign start_evt = sync2_reg[2] & ~start_prev_reg;

    // ==========================================================
    // AHB-Lite slave, zero wait states
    logic [11:0] a_addr_reg;
    logic [11:0] a_addr_next;
    swmc_bus_state_e bus_reg;
    swmc_bus_state_e bus_next;

    always_comb
    begin
        a_addr_next = a_addr_reg;
        bus_next = SWMC_BUS_IDLE;
        if (hsel && hready && htrans[1])
        begin
            a_addr_next = haddr;
            bus_next = hwrite ? SWMC_BUS_WRITE : SWMC_BUS_READ;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            a_addr_reg <= 12'h000;
            bus_reg <= SWMC_BUS_IDLE;
        end
        else
        begin
            a_addr_reg <= a_addr_next;
            bus_reg <= bus_next;
        end
    end

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    logic wr;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_port;
    logic wr_ien;
    logic wr_clr;
    always_comb
    begin
        wr = 1'b0;
        case (bus_reg)
            SWMC_BUS_WRITE: wr = 1'b1;
            SWMC_BUS_READ: wr = 1'b0;
            SWMC_BUS_IDLE: wr = 1'b0;
            default: wr = 1'b0;
        endcase
    end
    assign wr_ctrl = wr & hit(a_addr_reg, `SWMC_CTRL_OFS);
    assign wr_stat = wr & hit(a_addr_reg, `SWMC_STAT_OFS);
    assign wr_data = wr & hit(a_addr_reg, `SWMC_DATA_OFS);
    assign wr_port = wr & hit(a_addr_reg, `SWMC_PORT_OFS);
    assign wr_ien = wr & hit(a_addr_reg, `SWMC_IRQ_EN_OFS);
    assign wr_clr = wr & hit(a_addr_reg, `SWMC_IRQ_CLR_OFS);

    // ==========================================================
    // Control, port, data, counter and flags
    logic [5:0] ctrl_reg;
    logic [5:0] ctrl_next;
    logic [6:0] port_reg;
    logic [6:0] port_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic latch_reg;
    logic latch_next;
    logic [1:0] flag_reg;
    logic [1:0] flag_next;
    logic [1:0] ien_reg;
    logic [1:0] ien_next;
    logic din_prev_reg;
    logic din_prev_next;

    swmc_wire_mode_e wmode;
    swmc_clock_src_e csrc;
    logic strobe_sel;
    logic clk_strobe;
    logic tog_strobe;
    logic sh_tick;
    logic cnt_tick;
    logic two_wire;

    assign wmode = swmc_wire_mode_e'(ctrl_reg[`SWMC_CTRL_WM_LO+1 -: 2]);
    assign csrc = swmc_clock_src_e'(ctrl_reg[`SWMC_CTRL_CS_LO+1 -: 2]);
    assign strobe_sel = ctrl_reg[`SWMC_CTRL_CLK];
    assign two_wire = wmode[1];
    assign clk_strobe = wr_ctrl & hwdata[`SWMC_CTRL_CLK];
    assign tog_strobe = wr_ctrl & hwdata[`SWMC_CTRL_TC];

    always_comb
    begin
        sh_tick = 1'b0;
        cnt_tick = 1'b0;
        case (csrc)
            SWMC_CS_SOFT:
            begin
                sh_tick = clk_strobe;
                cnt_tick = clk_strobe;
            end
            SWMC_CS_TIMER:
            begin
                sh_tick = timer_ovf;
                cnt_tick = timer_ovf;
            end
            SWMC_CS_EXT_POS, SWMC_CS_EXT_NEG:
            begin
                sh_tick = (csrc == SWMC_CS_EXT_POS) ? scl_rise : scl_fall;
                cnt_tick = strobe_sel ? tog_strobe : (scl_rise | scl_fall);
            end
            default:
            begin
                sh_tick = 1'b0;
                cnt_tick = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        ctrl_next = ctrl_reg;
        port_next = port_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        ien_next = ien_reg;
        din_prev_next = din_s;
        if (wr_ctrl)
        begin
            ctrl_next[5:2] = hwdata[5:2];
            ctrl_next[1] = hwdata[`SWMC_CTRL_CLK] & hwdata[3];
            ctrl_next[0] = 1'b0;
        end
        if (wr_port)
            port_next = hwdata[6:0];
        if (tog_strobe)
            port_next[`SWMC_PORT_SCL] = ~port_next[`SWMC_PORT_SCL];
        // A write in the same cycle as a shift wins
        if (wr_data)
            shift_next = hwdata[7:0];
        else if (sh_tick)
            shift_next = {shift_reg[6:0],
                          (csrc == SWMC_CS_SOFT) ? din_prev_reg : din_s};
        if (wr_stat)
            cnt_next = hwdata[3:0];
        else if (cnt_tick)
            cnt_next = cnt_reg + 4'h1;
        if (wr_ien)
            ien_next = hwdata[1:0];
    end

    // latch follows MSB at once, or on opposite edge with external clock
    always_comb
    begin
        latch_next = latch_reg;
        if (!csrc[1])
            latch_next = shift_next[7];
        else if ((csrc == SWMC_CS_EXT_POS) ? scl_fall : scl_rise)
            latch_next = shift_reg[7];
    end

    logic ovf_evt;
    logic start_set;
    assign ovf_evt = cnt_tick & ~wr_stat & (cnt_reg == 4'hF);
    // no start detection in mode zero
    assign start_set = start_evt & two_wire;

    // Set wins over a clear in the same cycle
    always_comb
    begin
        flag_next = flag_reg;
        if (wr_clr)
            flag_next = flag_reg & ~hwdata[1:0];
        if (start_set)
            flag_next[`SWMC_ST_START] = 1'b1;
        if (ovf_evt)
            flag_next[`SWMC_ST_OVF] = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_reg <= 6'h00;
            port_reg <= 7'h00;
            shift_reg <= `SWMC_DATA_RST;
            cnt_reg <= `SWMC_CNT_RST;
            latch_reg <= 1'b0;
            flag_reg <= 2'h0;
            ien_reg <= 2'h0;
            din_prev_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            port_reg <= port_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            latch_reg <= latch_next;
            flag_reg <= flag_next;
            ien_reg <= ien_next;
            din_prev_reg <= din_prev_next;
        end
    end

    // ==========================================================
    // Pin drivers
    logic scl_hold;
    logic do_val;
    logic sda_val;
    logic scl_val;
    // overflow hold only in mode three
    assign scl_hold = two_wire & (flag_reg[`SWMC_ST_START] |
        ((wmode == SWMC_WM_TWO_HOLD) & flag_reg[`SWMC_ST_OVF]));
    assign do_val = (wmode == SWMC_WM_THREE) ? latch_reg
                                             : port_reg[`SWMC_PORT_DO];
    assign sda_val = latch_reg & port_reg[`SWMC_PORT_SDA];
    // SCL low on port zero or hold
    assign scl_val = port_reg[`SWMC_PORT_SCL] & ~scl_hold;

    always_comb
    begin
        // mode zero leaves plain port pins
        data_out_pin_out = do_val;
        data_out_pin_oe = port_reg[`SWMC_DDR_DO];
        data_out_pin_pullup = ~port_reg[`SWMC_DDR_DO] &
                              port_reg[`SWMC_PORT_DO];
        serial_data_in_pin_out = port_reg[`SWMC_PORT_SDA];
        serial_data_in_pin_oe = port_reg[`SWMC_DDR_SDA];
        serial_data_in_pin_pullup = ~port_reg[`SWMC_DDR_SDA] &
                                    port_reg[`SWMC_PORT_SDA];
        serial_clock_pin_out = port_reg[`SWMC_PORT_SCL];
        serial_clock_pin_oe = port_reg[`SWMC_DDR_SCL];
        serial_clock_pin_pullup = ~port_reg[`SWMC_DDR_SCL] &
                                  port_reg[`SWMC_PORT_SCL];
        if (two_wire)
        begin
            serial_data_in_pin_out = 1'b0;
            serial_data_in_pin_oe = port_reg[`SWMC_DDR_SDA] & ~sda_val;
            serial_clock_pin_out = 1'b0;
            serial_clock_pin_oe = port_reg[`SWMC_DDR_SCL] & ~scl_val;
            serial_data_in_pin_pullup = 1'b0;
            serial_clock_pin_pullup = 1'b0;
        end
    end

    // ==========================================================
    // Read data and interrupt
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic irq_reg;
    logic irq_next;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            if (hit(haddr, `SWMC_CTRL_OFS))
                rdata_next = {24'h000000, ien_next[0], ien_next[1],
                              ctrl_next[5:2], 2'b00};
            else if (hit(haddr, `SWMC_STAT_OFS))
                rdata_next = {24'h000000, flag_next[0], flag_next[1],
                              2'b00, cnt_next};
            else if (hit(haddr, `SWMC_DATA_OFS))
                rdata_next = {24'h000000, shift_next};
            else if (hit(haddr, `SWMC_PORT_OFS))
                rdata_next = {25'h0000000, port_next};
            else if (hit(haddr, `SWMC_IRQ_EN_OFS))
                rdata_next = {30'h00000000, ien_next};
            else
                rdata_next = 32'h0000_0000;
        end
        irq_next = |(flag_next & ien_next);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = irq_reg;
endmodule

// ### verification/swmc_far_end.sv
// Far-end serial device model: clock pulses, data level, pulled-up lines
`timescale 1ns/1ps

module swmc_far_end (
    // Device drivers
    input wire logic serial_data_in_pin_oe,
    input wire logic serial_data_in_pin_out,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_clock_pin_out,
    // Far-end data level and resolved lines
    input wire logic far_sda,
    output logic serial_data_in_pin_in,
    output logic serial_clock_pin_in
);
    logic gen = 1'b1;
    // Pulled-up lines: any party driving low wins
    assign serial_data_in_pin_in = far_sda &
        (serial_data_in_pin_oe ? serial_data_in_pin_out : 1'b1);
    assign serial_clock_pin_in = gen &
        (serial_clock_pin_oe ? serial_clock_pin_out : 1'b1);
    // Clock stands high between frames, 200 ns period inside
    task automatic pulse(input int n);
        #37;
        repeat (n)
        begin
            #100 gen = 1'b0;
            #100 gen = 1'b1;
        end
    endtask
endmodule

// ### verification/swmc_checker.sv
// Port checker for the serial wire block, with its bind
`timescale 1ns/1ps
`include "swmc_defs.svh"

module swmc_checker (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic data_out_pin_out,
    input wire logic data_out_pin_oe,
    input wire logic data_out_pin_pullup,
    input wire logic serial_data_in_pin_oe,
    input wire logic serial_data_in_pin_pullup,
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_clock_pin_pullup
);
    // ==========================================================
    // Shadow of mode and port bits, so pins can be judged alone
    logic [1:0] m_reg, m_next;
    logic [6:0] p_reg, p_next;
    logic [11:0] a_reg;
    logic w_reg, w_next, r_reg, r_next;
    always_comb
    begin
        m_next = m_reg;
        p_next = p_reg;
        w_next = hsel && hready && htrans[1] && hwrite;
        r_next = hsel && hready && htrans[1] && !hwrite;
        if (w_reg && a_reg == `SWMC_CTRL_OFS)
        begin
            m_next = hwdata[5:4];
            p_next[2] = p_reg[2] ^ hwdata[0];
        end
        if (w_reg && a_reg == `SWMC_PORT_OFS)
            p_next = hwdata[6:0];
    end
    always_ff @(posedge ref_clk)
    begin
        m_reg <= rst ? 2'h0 : m_next;
        p_reg <= rst ? 7'h00 : p_next;
        a_reg <= haddr;
        w_reg <= rst ? 1'b0 : w_next;
        r_reg <= rst ? 1'b0 : r_next;
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    off_pins_a: assert property (m_reg == 2'h0 |->
        data_out_pin_oe == p_reg[4] && (!p_reg[4] ||
        data_out_pin_out == p_reg[0])) else $error("off mode pin wrong");
    do_three_a: assert property (m_reg == 2'h1 |->
        data_out_pin_oe == p_reg[4] && (p_reg[4] ||
        data_out_pin_pullup == p_reg[0])) else $error("data out wrong");
    clk_three_a: assert property (m_reg == 2'h1 |->
        serial_clock_pin_oe == p_reg[6] && (!p_reg[6] ||
        serial_clock_pin_out == p_reg[2])) else $error("clock pin wrong");
    drv_gate_a: assert property (m_reg[1] |->
        (p_reg[5] || !serial_data_in_pin_oe) && (p_reg[6] ||
        !serial_clock_pin_oe)) else $error("driver without direction");
    sda_low_a: assert property (m_reg[1] && p_reg[5] && !p_reg[1]
        |-> serial_data_in_pin_oe) else $error("sda not pulled low");
    scl_low_a: assert property (m_reg[1] && p_reg[6] && !p_reg[2]
        |-> serial_clock_pin_oe && !serial_clock_pin_out)
        else $error("scl not pulled low");
    pull_off_a: assert property (m_reg[1] |->
        !serial_data_in_pin_pullup && !serial_clock_pin_pullup)
        else $error("pull-up on in two-wire");
    strobe_zero_a: assert property (r_reg &&
        a_reg == `SWMC_CTRL_OFS |-> hrdata[1:0] == 2'h0)
        else $error("strobe bits read back");
    cover property (m_reg == 2'h3 && serial_clock_pin_oe);
    cover property (r_reg && a_reg == `SWMC_STAT_OFS);
    cover property (w_reg && a_reg == `SWMC_CTRL_OFS && hwdata[1]);
endmodule

bind swmc_top swmc_checker chk_u (.ref_clk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .hrdata, .data_out_pin_out, .data_out_pin_oe,
    .data_out_pin_pullup, .serial_data_in_pin_oe, .serial_data_in_pin_pullup,
    .serial_clock_pin_out, .serial_clock_pin_oe, .serial_clock_pin_pullup);

// ### verification/test_serial_wire_mode_clock_select.sv
// Self-checking bench for the serial wire block
`timescale 1ns/1ps
`include "swmc_defs.svh"

module test_serial_wire_mode_clock_select;
    import swmc_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic timer_ovf = 1'b0, start_detect = 1'b0, far_sda = 1'b1;
    logic data_out_pin_in = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, seed = 32'h0000FBE1, hrdata, q;
    logic hready, hreadyout, hresp, irq;
    logic data_out_pin_out, data_out_pin_oe, data_out_pin_pullup;
    logic serial_data_in_pin_in, serial_data_in_pin_out;
    logic serial_data_in_pin_oe, serial_data_in_pin_pullup;
    logic serial_clock_pin_in, serial_clock_pin_out;
    logic serial_clock_pin_oe, serial_clock_pin_pullup;
    logic [7:0] d;
    logic [11:0] ofs [6] = '{`SWMC_CTRL_OFS, `SWMC_STAT_OFS,
        `SWMC_DATA_OFS, `SWMC_PORT_OFS, `SWMC_IRQ_EN_OFS, 12'h020};
    int err_count = 0, n_checks = 0, cyc = 0;

    assign hready = hreadyout;
    swmc_top dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_ovf,
        .data_out_pin_in, .data_out_pin_out, .data_out_pin_oe,
        .data_out_pin_pullup, .serial_data_in_pin_in,
        .serial_data_in_pin_out, .serial_data_in_pin_oe,
        .serial_data_in_pin_pullup, .serial_clock_pin_in,
        .serial_clock_pin_out, .serial_clock_pin_oe,
        .serial_clock_pin_pullup, .start_detect, .irq);
    swmc_far_end wire_u (.serial_data_in_pin_oe, .serial_data_in_pin_out,
        .serial_clock_pin_oe, .serial_clock_pin_out, .far_sda,
        .serial_data_in_pin_in, .serial_clock_pin_in);

    initial
        forever #12.5 ref_clk = ~ref_clk;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] shl(input logic [7:0] v, input logic b,
        input int n);
        repeat (n) v = {v[6:0], b};
        return v;
    endfunction
    task automatic chk_reg(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    // Caller stands just after a rising edge; returns just after one
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] v);
        int t;
        t = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1 && ++t < 99);
        htrans <= 2'h0;
        hwdata <= v;
        do @(posedge ref_clk); while (hready !== 1'b1 && ++t < 99);
        q = hrdata;
        if (t >= 99)
            err_count++;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_reg($sformatf("reg %h", a), e, q);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (ofs[i])
            rd(ofs[i], 32'h0);
        wr(12'h020, 32'hFFFFFFFF);
        rd(12'h020, 32'h0);
        wr(`SWMC_PORT_OFS, 32'h10);
        for (int i = 1; i < 5; i++)
        begin
            d = 8'(rnd());
            far_sda <= seed[9];
            wr(`SWMC_DATA_OFS, {24'h0, d});
            wr(`SWMC_CTRL_OFS, 32'h0);
            repeat (4) @(posedge ref_clk);
            rd(`SWMC_STAT_OFS, 32'(i - 1));
            wr(`SWMC_CTRL_OFS, 32'h2);
            rd(`SWMC_DATA_OFS, {24'h0, shl(d, far_sda, 1)});
            rd(`SWMC_CTRL_OFS, 32'h0);
        end
        wr(`SWMC_CTRL_OFS, 32'h10);
        wr(`SWMC_DATA_OFS, 32'h80);
        #1 chk_pin("data out", 1'b1, data_out_pin_out);
        wr(`SWMC_DATA_OFS, 32'h7F);
        #1 chk_pin("data out", 1'b0, data_out_pin_out);
        wr(`SWMC_CTRL_OFS, 32'h11);
        rd(`SWMC_PORT_OFS, 32'h14);
        wr(`SWMC_CTRL_OFS, 32'h11);
        rd(`SWMC_PORT_OFS, 32'h10);
        far_sda <= 1'b1;
        wr(`SWMC_CTRL_OFS, 32'h04);
        wr(`SWMC_STAT_OFS, 32'h0);
        wr(`SWMC_DATA_OFS, {24'h0, d});
        repeat (3)
        begin
            timer_ovf <= 1'b1;
            @(posedge ref_clk);
            timer_ovf <= 1'b0;
            @(posedge ref_clk);
        end
        wr(`SWMC_CTRL_OFS, 32'h06);
        rd(`SWMC_STAT_OFS, 32'h3);
        rd(`SWMC_DATA_OFS, {24'h0, shl(d, 1'b1, 3)});
        for (int cs = 2; cs < 4; cs++)
        begin
            wr(`SWMC_CTRL_OFS, 32'(cs << 2));
            wr(`SWMC_STAT_OFS, 32'h0);
            wr(`SWMC_DATA_OFS, {24'h0, d});
            wire_u.pulse(3);
            repeat (6) @(posedge ref_clk);
            rd(`SWMC_STAT_OFS, 32'h6);
            rd(`SWMC_DATA_OFS, {24'h0, shl(d, 1'b1, 3)});
        end
        wr(`SWMC_CTRL_OFS, 32'h0A);
        wr(`SWMC_STAT_OFS, 32'h0);
        wire_u.pulse(2);
        repeat (6) @(posedge ref_clk);
        wr(`SWMC_CTRL_OFS, 32'h0B);
        wr(`SWMC_CTRL_OFS, 32'h0B);
        rd(`SWMC_STAT_OFS, 32'h2);
        wr(`SWMC_PORT_OFS, 32'h66);
        wr(`SWMC_CTRL_OFS, 32'h20);
        wr(`SWMC_DATA_OFS, 32'h00);
        #1 chk_pin("sda oe", 1'b1, serial_data_in_pin_oe);
        wr(`SWMC_DATA_OFS, 32'h80);
        #1 chk_pin("sda oe", 1'b0, serial_data_in_pin_oe);
        wr(`SWMC_PORT_OFS, 32'h60);
        #1 chk_pin("scl oe", 1'b1, serial_clock_pin_oe);
        wr(`SWMC_PORT_OFS, 32'h66);
        wr(`SWMC_IRQ_EN_OFS, 32'h1);
        start_detect <= 1'b1;
        repeat (6) @(posedge ref_clk);
        start_detect <= 1'b0;
        #1 chk_pin("scl hold", 1'b1, serial_clock_pin_oe);
        chk_pin("irq", 1'b1, irq);
        rd(`SWMC_STAT_OFS, 32'h82);
        wr(`SWMC_IRQ_EN_OFS, 32'h0);
        @(posedge ref_clk);
        #1 chk_pin("irq", 1'b0, irq);
        wr(`SWMC_IRQ_CLR_OFS, 32'h1);
        @(posedge ref_clk);
        #1 chk_pin("scl hold", 1'b0, serial_clock_pin_oe);
        for (int m = 2; m < 4; m++)
        begin
            wr(`SWMC_CTRL_OFS, 32'(m << 4));
            wr(`SWMC_STAT_OFS, 32'hF);
            wr(`SWMC_CTRL_OFS, 32'(m << 4 | 2));
            @(posedge ref_clk);
            #1 chk_pin("scl ovf", m == 3, serial_clock_pin_oe);
            rd(`SWMC_STAT_OFS, 32'h40);
            wr(`SWMC_IRQ_CLR_OFS, 32'h2);
            @(posedge ref_clk);
            #1 chk_pin("scl ovf", 1'b0, serial_clock_pin_oe);
        end
        summarize();
    end
endmodule
